// File: gpc_pad_ctrl.v
/*
 * Pad configuration and manual pin control for a 19-pin general-purpose port.
 * Holds direction, group source select, drive boost and slew per pin, drives
 * manual output levels and samples input pins through two flip-flops.
 * All registers and pad outputs clear on reset, so every pin starts as an input.
 * Unmapped offsets ignore writes and read zero; the register port never stalls.
 * Level bits of input pins and of non-manual groups never reach the pads.
 * Assumes a plain register port (one-cycle strobes, read data next cycle) and
 * a second crosspoint source supplied from elsewhere in the device.
 * Assumes pad inputs are asynchronous, while claims and function outputs
 * come from logic on this same clock.
 */
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "gpc_consts.vh"

module gpc_pad_ctrl #(
    parameter NUM_PINS = `GPC_NUM_PINS
) (
    // Clock and reset
    input  wire                  i_core_clk,
    input  wire                  i_sys_rst,
    // Register port
    input  wire [7:0]            i_reg_addr,
    input  wire [31:0]           i_reg_wdata,
    input  wire                  i_reg_wr,
    input  wire                  i_reg_rd,
    output reg  [31:0]           o_reg_rdata,
    // Second crosspoint
    input  wire [NUM_PINS-1:0]   i_xp2_claim,
    input  wire [NUM_PINS-1:0]   i_xp2_oe,
    input  wire [NUM_PINS-1:0]   i_xp2_out,
    // Other first-crosspoint functions
    input  wire [NUM_PINS-1:0]   i_xp1_func_out,
    // Pads
    input  wire [NUM_PINS-1:0]   i_pad_in,
    output reg  [NUM_PINS-1:0]   o_pad_out,
    output reg  [NUM_PINS-1:0]   o_pad_oe,
    output reg  [NUM_PINS-1:0]   o_pad_drive_boost,
    output reg  [2*NUM_PINS-1:0] o_pad_slew
);
    // Configuration registers
    reg  [NUM_PINS-1:0]   pin_direction_mask_r;
    reg  [31:0]           source_select_nibbles_r;
    reg  [NUM_PINS-1:0]   drive_boost_mask_r;
    reg  [NUM_PINS-1:0]   slew_pin_select_r;
    reg  [NUM_PINS-1:0]   output_level_r;
    reg  [NUM_PINS-1:0]   slew_rd_sel_r;
    // Input synchroniser
    reg  [NUM_PINS-1:0]   pad_in_meta_r;
    reg  [NUM_PINS-1:0]   pad_in_sync_r;
    // Write strobes per register
    wire                  wr_dir;
    wire                  wr_src;
    wire                  wr_drv;
    wire                  wr_slew_sel;
    wire                  wr_slew_rd;
    wire                  wr_lvl_out;
    // Derived nets
    wire [NUM_PINS-1:0]   drv_expanded;
    wire [NUM_PINS-1:0]   slew_sel_expanded;
    wire [NUM_PINS-1:0]   manual_mask;
    wire [1:0]            slew_rd_setting;
    wire [2*NUM_PINS-1:0] slew_settings;
    wire                  slew_wr;
    reg  [31:0]           rdata_nxt;
    reg  [NUM_PINS-1:0]   pad_out_nxt;
    reg  [NUM_PINS-1:0]   pad_oe_nxt;
    reg  [NUM_PINS-1:0]   boost_nxt;
    reg  [2*NUM_PINS-1:0] slew_nxt;
    integer p;

    // Pair expansion for drive boost writes
    gpc_pair_expand #(
        .NUM_PINS (NUM_PINS)
    ) u_drv_pair (
        .i_mask (i_reg_wdata[NUM_PINS-1:0]),
        .o_mask (drv_expanded)
    );

    // Pair expansion for slew select
    gpc_pair_expand #(
        .NUM_PINS (NUM_PINS)
    ) u_slew_pair (
        .i_mask (slew_pin_select_r),
        .o_mask (slew_sel_expanded)
    );

    // Writing the setting register applies it to the selected pins
    assign slew_wr = i_reg_wr && (i_reg_addr == `GPC_ADDR_SLEW_SET);

    // Per-pin slew store
    gpc_slew_bank #(
        .NUM_PINS (NUM_PINS)
    ) u_slew (
        .i_core_clk   (i_core_clk),
        .i_sys_rst    (i_sys_rst),
        .i_wr         (slew_wr),
        .i_sel        (slew_sel_expanded),
        .i_setting    (i_reg_wdata[1:0]),
        .i_rd_sel     (slew_rd_sel_r),
        .o_rd_setting (slew_rd_setting),
        .o_settings   (slew_settings)
    );

    // Manual mode per group: nibble g covers pins 4g..4g+3, last group 16-18
    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g = g + 1) begin : g_grp
            assign manual_mask[g] = (source_select_nibbles_r[4*(g/`GPC_GROUP_SIZE)+3 -: 4]
                                     == `GPC_SRC_MANUAL);
        end
    endgenerate

    // Write decode, one strobe per writable offset except GPC_ADDR_SLEW_SET (decoded above); unmapped offsets hit none
    assign wr_dir      = i_reg_wr && (i_reg_addr == `GPC_ADDR_DIR);
    assign wr_src      = i_reg_wr && (i_reg_addr == `GPC_ADDR_SRC);
    assign wr_drv      = i_reg_wr && (i_reg_addr == `GPC_ADDR_DRV);
    assign wr_slew_sel = i_reg_wr && (i_reg_addr == `GPC_ADDR_SLEW_SEL);
    assign wr_slew_rd  = i_reg_wr && (i_reg_addr == `GPC_ADDR_SLEW_RD);
    assign wr_lvl_out  = i_reg_wr && (i_reg_addr == `GPC_ADDR_LVL_OUT);

    // Pin direction, one means output
    always @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            pin_direction_mask_r <= `GPC_DIR_RST;
        end else if (wr_dir) begin
            pin_direction_mask_r <= i_reg_wdata[NUM_PINS-1:0];
        end
    end

    // Group source nibbles of the first crosspoint
    always @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            source_select_nibbles_r <= `GPC_SRC_RST;
        end else if (wr_src) begin
            source_select_nibbles_r <= i_reg_wdata;
        end
    end

    // Drive boost mask, stored already pair expanded
    always @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            drive_boost_mask_r <= `GPC_DRV_RST;
        end else if (wr_drv) begin
            drive_boost_mask_r <= drv_expanded;
        end
    end

    // Raw slew pin select; pairing is applied at update time
    always @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            slew_pin_select_r <= `GPC_DRV_RST;
        end else if (wr_slew_sel) begin
            slew_pin_select_r <= i_reg_wdata[NUM_PINS-1:0];
        end
    end

    // One-hot pin select for slew readback
    always @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            slew_rd_sel_r <= `GPC_DRV_RST;
        end else if (wr_slew_rd) begin
            slew_rd_sel_r <= i_reg_wdata[NUM_PINS-1:0];
        end
    end

    // Manual output level word
    always @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            output_level_r <= `GPC_LVL_RST;
        end else if (wr_lvl_out) begin
            output_level_r <= i_reg_wdata[NUM_PINS-1:0];
        end
    end

    // Synchroniser first stage, may go metastable on a pad edge
    always @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            pad_in_meta_r <= `GPC_LVL_RST;
        end else begin
            pad_in_meta_r <= i_pad_in;
        end
    end

    // Synchroniser second stage, the only reader of the first
    always @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            pad_in_sync_r <= `GPC_LVL_RST;
        end else begin
            pad_in_sync_r <= pad_in_meta_r;
        end
    end

    // Read data mux; unmapped offsets read zero
    always @* begin
        rdata_nxt = 32'h0000_0000;
        case (i_reg_addr)
            `GPC_ADDR_DIR:      rdata_nxt[NUM_PINS-1:0] = pin_direction_mask_r;
            `GPC_ADDR_SRC:      rdata_nxt = source_select_nibbles_r;
            `GPC_ADDR_DRV:      rdata_nxt[NUM_PINS-1:0] = drive_boost_mask_r;
            `GPC_ADDR_SLEW_SEL: rdata_nxt[NUM_PINS-1:0] = slew_pin_select_r;
            `GPC_ADDR_SLEW_SET: rdata_nxt[1:0] = slew_rd_setting;
            `GPC_ADDR_SLEW_RD:  rdata_nxt[1:0] = slew_rd_setting;
            `GPC_ADDR_LVL_OUT:  rdata_nxt[NUM_PINS-1:0] = output_level_r;
            `GPC_ADDR_LVL_IN:   rdata_nxt[NUM_PINS-1:0] = pad_in_sync_r & ~pin_direction_mask_r
                                                          & manual_mask;
            default:            rdata_nxt = 32'h0000_0000;
        endcase
    end

    // Read data register, valid the cycle after the strobe
    always @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_reg_rdata <= 32'h0000_0000;
        end else if (i_reg_rd) begin
            o_reg_rdata <= rdata_nxt;
        end else begin
            o_reg_rdata <= 32'h0000_0000;
        end
    end

    // Per-pin pad drive selection
    always @* begin
        pad_out_nxt = `GPC_LVL_RST;
        pad_oe_nxt  = `GPC_LVL_RST;
        boost_nxt   = `GPC_DRV_RST;
        slew_nxt    = {2*NUM_PINS{1'b0}};
        for (p = 0; p < NUM_PINS; p = p + 1) begin
            if (i_xp2_claim[p]) begin
                pad_oe_nxt[p]  = i_xp2_oe[p];
                pad_out_nxt[p] = i_xp2_out[p];
            end else begin
                pad_oe_nxt[p] = pin_direction_mask_r[p];
                if (manual_mask[p]) begin
                    pad_out_nxt[p] = output_level_r[p] & pin_direction_mask_r[p];
                end else begin
                    pad_out_nxt[p] = i_xp1_func_out[p] & pin_direction_mask_r[p];
                end
            end
            if (pad_oe_nxt[p]) begin
                boost_nxt[p]      = drive_boost_mask_r[p];
                slew_nxt[2*p +: 2] = slew_settings[2*p +: 2];
            end
        end
    end

    // Registered pad output levels
    always @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_pad_out <= `GPC_LVL_RST;
        end else begin
            o_pad_out <= pad_out_nxt;
        end
    end

    // Registered pad output enables, low during reset so pins float as inputs
    always @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_pad_oe <= `GPC_LVL_RST;
        end else begin
            o_pad_oe <= pad_oe_nxt;
        end
    end

    // Registered drive boost per pad
    always @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_pad_drive_boost <= `GPC_DRV_RST;
        end else begin
            o_pad_drive_boost <= boost_nxt;
        end
    end

    // Registered slew per pad, two bits each
    always @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_pad_slew <= {2*NUM_PINS{1'b0}};
        end else begin
            o_pad_slew <= slew_nxt;
        end
    end
endmodule

// File: gpc_consts.vh
/*
 * Constants for the pad configuration and manual pin control block:
 * register offsets, field layout, reset values and mode codes.
 * Assumes a 32-bit plain register port with byte offsets that are word aligned.
 */
`ifndef GPC_CONSTS_VH
`define GPC_CONSTS_VH

// Register offsets
`define GPC_ADDR_DIR        8'h00
`define GPC_ADDR_SRC        8'h04
`define GPC_ADDR_DRV        8'h08
`define GPC_ADDR_SLEW_SEL   8'h0C
`define GPC_ADDR_SLEW_SET   8'h10
`define GPC_ADDR_SLEW_RD    8'h14
`define GPC_ADDR_LVL_OUT    8'h18
`define GPC_ADDR_LVL_IN     8'h1C

// Pin counts and pairing range
`define GPC_NUM_PINS        19
`define GPC_PAIR_LO         8
`define GPC_PAIR_HI         17
`define GPC_NUM_GROUPS      5
`define GPC_GROUP_SIZE      4

// Reset values
`define GPC_DIR_RST         19'h0_0000
`define GPC_SRC_RST         32'h0000_0000
`define GPC_DRV_RST         19'h0_0000
`define GPC_LVL_RST         19'h0_0000
`define GPC_SLEW_RST        2'h0

// Slew encodings
`define GPC_SLEW_LOWEST     2'h0
`define GPC_SLEW_LOW        2'h1
`define GPC_SLEW_MEDIUM     2'h2
`define GPC_SLEW_HIGH       2'h3

// Group source codes
`define GPC_SRC_MANUAL      4'h3

`endif

// File: gpc_pair_expand.v
/*
 * Pair expansion of a per-pin mask: for pins 8 to 17, a set bit in a pair
 * sets both bits of that pair. Purely combinational.
 * Assumes pairs are (8,9),(10,11),(12,13),(14,15),(16,17).
 */
`timescale 1ns/1ps
`include "gpc_consts.vh"

module gpc_pair_expand #(
    parameter NUM_PINS = `GPC_NUM_PINS
) (
    // Mask in and out
    input  wire [NUM_PINS-1:0] i_mask,
    output wire [NUM_PINS-1:0] o_mask
);
    genvar g;
    // Each pin ORs in its partner when inside the paired range
    generate
        for (g = 0; g < NUM_PINS; g = g + 1) begin : g_pin
            if (g >= `GPC_PAIR_LO && g <= `GPC_PAIR_HI) begin : g_pair
                assign o_mask[g] = i_mask[g] | i_mask[g ^ 1];
            end else begin : g_single
                assign o_mask[g] = i_mask[g];
            end
        end
    endgenerate
endmodule

// File: gpc_slew_bank.v
/*
 * Per-pin slew setting store, two bits per pin, with masked update and
 * one-hot readback. Assumes the select mask is already pair expanded.
 */
`timescale 1ns/1ps
`include "gpc_consts.vh"

module gpc_slew_bank #(
    parameter NUM_PINS = `GPC_NUM_PINS
) (
    // Clock and reset
    input  wire                  i_core_clk,
    input  wire                  i_sys_rst,
    // Update
    input  wire                  i_wr,
    input  wire [NUM_PINS-1:0]   i_sel,
    input  wire [1:0]            i_setting,
    // Readback
    input  wire [NUM_PINS-1:0]   i_rd_sel,
    output reg  [1:0]            o_rd_setting,
    // Flattened settings
    output wire [2*NUM_PINS-1:0] o_settings
);
    reg [1:0] slew_r [0:NUM_PINS-1];
    integer k;

    genvar g;
    // Each selected pin takes the new setting, others keep theirs
    generate
        for (g = 0; g < NUM_PINS; g = g + 1) begin : g_pin
            always @(posedge i_core_clk) begin
                if (i_sys_rst) begin
                    slew_r[g] <= `GPC_SLEW_RST;
                end else if (i_wr && i_sel[g]) begin
                    slew_r[g] <= i_setting;
                end
            end
            assign o_settings[2*g+1:2*g] = slew_r[g];
        end
    endgenerate

    // One-hot readback: OR of selected entries
    always @* begin
        o_rd_setting = 2'h0;
        for (k = 0; k < NUM_PINS; k = k + 1) begin
            if (i_rd_sel[k]) begin
                o_rd_setting = o_rd_setting | slew_r[k];
            end
        end
    end
endmodule

// File: gpc_pad_ctrl_sva.sv
/*
 * Port checker for the pad control block: read port, pad gating, pairs.
 * Assumes it is bound to gpc_pad_ctrl and shares its single clock.
 */
`timescale 1ns/1ps
`include "gpc_consts.vh"
module gpc_pad_sva #(
    parameter NUM_PINS = 19
) (
    // Watched ports
    input wire logic                  i_core_clk,
    input wire logic                  i_sys_rst,
    input wire logic [7:0]            i_reg_addr,
    input wire logic                  i_reg_rd,
    input wire logic [NUM_PINS-1:0]   i_xp2_claim,
    input wire logic [NUM_PINS-1:0]   i_xp2_oe,
    input wire logic [31:0]           o_reg_rdata,
    input wire logic [NUM_PINS-1:0]   o_pad_out,
    input wire logic [NUM_PINS-1:0]   o_pad_oe,
    input wire logic [NUM_PINS-1:0]   o_pad_drive_boost,
    input wire logic [2*NUM_PINS-1:0] o_pad_slew
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);
    // Claims of the previous cycle, matching the registered pad outputs
    reg  [NUM_PINS-1:0]   cl_q;
    wire [NUM_PINS-1:0]   drv_ok = o_pad_oe;
    wire [NUM_PINS-1:0]   own = o_pad_oe & ~cl_q;
    wire [2*NUM_PINS-1:0] drv_ok2;
    wire [4:0]            pair_bad;
    always @(posedge i_core_clk) cl_q <= i_xp2_claim;
    // Per-pin enable widened to the slew field, and pair mismatches
    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g = g + 1) begin : g_oe
            assign drv_ok2[2*g+1:2*g] = {2{drv_ok[g]}};
        end
        for (g = 0; g < 5; g = g + 1) begin : g_pr
            assign pair_bad[g] = (&own[2*g+9:2*g+8]) && (o_pad_drive_boost[2*g+8] != o_pad_drive_boost[2*g+9]);
        end
    endgenerate
    rd_idle_zero_a: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 32'h0000_0000)
        else $error("read data not zero outside a read");
    rd_upper_zero_a: assert property ($past(i_reg_rd) && ($past(i_reg_addr) != `GPC_ADDR_SRC) |-> o_reg_rdata[31:19] == 13'h0)
        else $error("read data upper bits not zero");
    rst_pads_clear_a: assert property ($past(i_sys_rst) |-> o_pad_drive_boost == 0 && o_pad_slew == 0)
        else $error("pad settings not clear after reset");
    xp2_priority_a: assert property ((o_pad_oe & $past(i_xp2_claim)) == ($past(i_xp2_oe) & $past(i_xp2_claim)))
        else $error("second crosspoint enable not on claimed pin");
    out_gate_a: assert property ((o_pad_out & ~o_pad_oe & ~cl_q) == 0)
        else $error("level driven on input pin");
    boost_gate_a: assert property ((o_pad_drive_boost & ~drv_ok) == 0)
        else $error("drive boost on input pin");
    slew_gate_a: assert property ((o_pad_slew & ~drv_ok2) == 0)
        else $error("slew on input pin");
    boost_pair_a: assert property (pair_bad == 5'h0)
        else $error("drive boost differs within a pair");
endmodule

// File: gpc_bbp_model.sv
/*
 * Baseband processor model on the pads.
 * Assumes pad enables are high where the device drives the wire.
 */
`timescale 1ns/1ps
module gpc_bbp_model (
    // Pad side
    input  wire logic [18:0] i_pad_out,
    input  wire logic [18:0] i_pad_oe,
    input  wire logic [18:0] i_drive,
    output wire logic [18:0] o_pad_in
);
    // Wire carries the device level where it drives, else our own level
    assign o_pad_in = (i_pad_out & i_pad_oe) | (i_drive & ~i_pad_oe);
endmodule

// File: testbench.sv
/*
 * Self-checking bench for gpc_pad_ctrl with a processor model on the pads.
 * Assumes read data stand in the cycle after the read strobe.
 */
`timescale 1ns/1ps
`include "gpc_consts.vh"
module testbench;
    reg         clk = 1'b0;
    reg         rst = 1'b1;
    reg  [7:0]  addr = 8'h00;
    reg  [31:0] wdata = 32'h0000_0000;
    reg         wr = 1'b0;
    reg         rd = 1'b0;
    reg  [18:0] cl = 19'h0, xoe = 19'h0, xo = 19'h0, fo = 19'h0, bd = 19'h0;
    reg  [18:0] dir, lvl, e;
    reg  [1:0]  slw [0:18];
    reg  [31:0] expq [$];
    reg         pend = 1'b0;
    wire [31:0] rdata;
    wire [18:0] pin, pout, poe, pbst;
    wire [37:0] pslw;
    integer     fails = 0, compares = 0, i, k, p;
    initial forever #25 clk = ~clk;
    gpc_pad_ctrl uut (.i_core_clk(clk), .i_sys_rst(rst), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_xp2_claim(cl), .i_xp2_oe(xoe),
        .i_xp2_out(xo), .i_xp1_func_out(fo), .i_pad_in(pin), .o_pad_out(pout), .o_pad_oe(poe),
        .o_pad_drive_boost(pbst), .o_pad_slew(pslw));
    gpc_bbp_model bbp (.i_pad_out(pout), .i_pad_oe(poe), .i_drive(bd), .o_pad_in(pin));
    task chk(input [37:0] got, input [37:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    // Register read results
    task chk_rd(input [31:0] got, input [31:0] exp);
        begin
            chk({6'h0, got}, {6'h0, exp});
        end
    endtask
    // One bus cycle: 0 idle, 1 write, 2 read with expected data noted
    task bus(input [1:0] kd, input [7:0] a, input [31:0] d);
        begin
            @(posedge clk);
            wr <= (kd == 2'h1);
            rd <= (kd == 2'h2);
            addr <= a;
            wdata <= d;
            if (kd == 2'h2) expq.push_back(d);
        end
    endtask
    task pads(input [18:0] eoe, input [18:0] eout, input [18:0] eb, input [37:0] es);
        begin
            bus(2'h0, 8'h00, 32'h0000_0000);
            repeat (2) @(posedge clk);
            #1;
            chk(poe, eoe);
            chk(pout, eout);
            chk(pbst, eb);
            chk(pslw, es);
        end
    endtask
    function [18:0] px(input [18:0] m);
        integer j;
        begin
            px = m;
            for (j = 8; j < 18; j = j + 2) if (m[j] | m[j+1]) px[j +: 2] = 2'h3;
        end
    endfunction
    function [37:0] sv2(input [18:0] m);
        integer j;
        begin
            sv2 = 38'h0;
            for (j = 0; j < 19; j = j + 1) if (m[j]) sv2[2*j +: 2] = slw[j];
        end
    endfunction
    // Read results are compared one cycle after their strobe
    always @(posedge clk) begin
        if (pend) chk_rd(rdata, expq.pop_front());
        pend <= rd;
    end
    task close_out;
        begin
            $display("compares=%0d fails=%0d", compares, fails);
            if (fails == 0 && compares > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    initial begin
        #1000000;
        fails = fails + 1;
        close_out;
    end
    initial begin
        k = $urandom(32'hb3919910);
        for (i = 0; i < 19; i = i + 1) slw[i] = 2'h0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        // Reset values, unmapped offset 0x20 included
        for (k = 0; k <= 32; k = k + 4) bus(2'h2, k[7:0], 32'h0000_0000);
        k = $urandom;
        dir = k[18:0];
        bus(2'h1, `GPC_ADDR_DIR, {13'h0, dir});
        bus(2'h1, `GPC_ADDR_SRC, 32'h0003_3333);
        bus(2'h2, `GPC_ADDR_DIR, {13'h0, dir});
        bus(2'h2, `GPC_ADDR_SRC, 32'h0003_3333);
        // Drive boost, one bit at a time
        for (p = 0; p < 19; p = p + 1) begin
            bus(2'h1, `GPC_ADDR_DRV, 32'h1 << p);
            bus(2'h2, `GPC_ADDR_DRV, {13'h0, px(19'h1 << p)});
            pads(dir, 19'h0, px(19'h1 << p) & dir, 38'h0);
        end
        // Slew updates on random pins, every setting, full readback
        for (k = 0; k < 8; k = k + 1) begin
            p = $urandom % 19;
            e = px(19'h1 << p);
            bus(2'h1, `GPC_ADDR_SLEW_SEL, 32'h1 << p);
            bus(2'h1, `GPC_ADDR_SLEW_SET, {30'h0, k[1:0]});
            for (i = 0; i < 19; i = i + 1) if (e[i]) slw[i] = k[1:0];
            for (i = 0; i < 19; i = i + 1) begin
                bus(2'h1, `GPC_ADDR_SLEW_RD, 32'h1 << i);
                bus(2'h2, `GPC_ADDR_SLEW_RD, {30'h0, slw[i]});
            end
            pads(dir, 19'h0, 19'h4_0000 & dir, sv2(dir));
        end
        // Manual levels out and in
        k = $urandom;
        lvl = k[18:0];
        k = $urandom;
        bd <= k[18:0];
        fo <= ~k[18:0];
        bus(2'h1, `GPC_ADDR_LVL_OUT, {13'h0, lvl});
        bus(2'h2, `GPC_ADDR_LVL_OUT, {13'h0, lvl});
        pads(dir, lvl & dir, 19'h4_0000 & dir, sv2(dir));
        bus(2'h2, `GPC_ADDR_LVL_IN, {13'h0, bd & ~dir});
        // Each group taken out of manual mode in turn
        for (k = 0; k < 5; k = k + 1) begin
            bus(2'h1, `GPC_ADDR_SRC, 32'h0003_3333 & ~(32'hf << 4*k));
            bus(2'h0, 8'h00, 32'h0000_0000);
            bus(2'h2, `GPC_ADDR_LVL_IN, {13'h0, bd & ~dir & ~(19'hf << 4*k)});
            e = 19'hf << 4*k;
            pads(dir, (lvl & dir & ~e) | (fo & dir & e), 19'h4_0000 & dir, sv2(dir));
        end
        bus(2'h1, `GPC_ADDR_SRC, 32'h0003_3333);
        // Second crosspoint claims random pins
        k = $urandom;
        cl <= k[18:0];
        k = $urandom;
        xoe <= k[18:0];
        xo <= ~k[18:0];
        bus(2'h0, 8'h00, 32'h0000_0000);
        repeat (2) @(posedge clk);
        #1;
        chk(poe, (xoe & cl) | (dir & ~cl));
        chk(pout & ~cl, lvl & dir & ~cl);
        chk(pout & cl, xo & cl);
        chk(pbst, 19'h4_0000 & ((xoe & cl) | (dir & ~cl)));
        chk(pslw, sv2((xoe & cl) | (dir & ~cl)));
        for (i = 0; i < 20 && expq.size() > 0; i = i + 1) @(posedge clk);
        if (expq.size() > 0) fails = fails + 1;
        close_out;
    end
endmodule
bind gpc_pad_ctrl gpc_pad_sva #(.NUM_PINS(NUM_PINS)) sva (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
    .i_reg_addr(i_reg_addr), .i_reg_rd(i_reg_rd), .i_xp2_claim(i_xp2_claim), .i_xp2_oe(i_xp2_oe),
    .o_reg_rdata(o_reg_rdata), .o_pad_out(o_pad_out), .o_pad_oe(o_pad_oe),
    .o_pad_drive_boost(o_pad_drive_boost), .o_pad_slew(o_pad_slew));
